// File: hw/dpd_pkg.sv
// Purpose: Shared constants and types for the oscillator, divider and mode logic.
// Assumes: System clock of 100 MHz; the loop filter and phase detector sit outside.
// Notes: Frequency words are phase increments of a 32-bit accumulator per system clock.
package dpd_pkg;
  localparam longint unsigned CLK_HZ = 64'd100000000;
  localparam longint unsigned FAST_HZ = 64'd65536000;
  localparam longint unsigned FRAME_HZ = 64'd8000;
  localparam longint unsigned T1_KHZ = 64'd1544;
  localparam longint unsigned FAST_KHZ = 64'd65536;
  localparam longint unsigned LOCK_TIME_S = 64'd50;
  localparam longint unsigned STORE_TIME_MS = 64'd32;
  localparam longint unsigned FREERUN_OFS_PPB = 64'd30;
  localparam longint unsigned SLOPE_NS_X10 = 64'd76;
  localparam longint unsigned SLOPE_WIN_NS_X10 = 64'd1250000;
  localparam logic [32:0] LOCK_CYCLES_DEF = 33'(LOCK_TIME_S * CLK_HZ);
  localparam logic [21:0] STORE_CYCLES_DEF = 22'(STORE_TIME_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] FCW_NOM = 32'((FAST_HZ << 32) / CLK_HZ);
  localparam logic [31:0] FCW_FREE_OFS = 32'(64'(FCW_NOM) * FREERUN_OFS_PPB / 64'd1000000000);
  localparam logic signed [31:0] SLOPE_LIM = 32'(64'(FCW_NOM) * SLOPE_NS_X10 / SLOPE_WIN_NS_X10);
  localparam logic [15:0] T1_INC = 16'((T1_KHZ << 16) / FAST_KHZ);
  localparam logic [12:0] FRAME_LAST = 13'(FAST_HZ / FRAME_HZ - 64'd1);
  localparam logic [12:0] FRAME_HALF = 13'h0004;
  localparam int BITCLK_BIT = 2;
  localparam int E1_BIT = 4;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_HKEEP = 4'h1;
  localparam logic [3:0] ADDR_HOLD_LO = 4'h2;
  localparam logic [3:0] ADDR_HOLD_HI = 4'h3;
  localparam int MODE_FDM_LSB = 0;
  localparam int MODE_HOLD_RST = 2;
  localparam int MODE_PREF_SEC = 3;
  localparam int MODE_FREQ_LSB = 4;
  localparam int MODE_PRI_MASTER = 6;
  localparam logic [6:0] MODE_RESET = 7'h40;
  localparam logic [1:0] FDM_STATUS = 2'h0;
  localparam logic [1:0] FDM_PINS = 2'h1;
  localparam int SYNC_W = 8;
  localparam int S_PRIMARY_REFERENCE = 0;
  localparam int S_SECONDARY_REFERENCE = 1;
  localparam int S_GRP_A = 2;
  localparam int S_GRP_B = 3;
  localparam int S_FRM_A = 4;
  localparam int S_FRM_B = 5;
  localparam int S_LOS_PRI = 6;
  localparam int S_LOS_SEC = 7;
  typedef enum logic [1:0] {
    FREQ_8K = 2'h0,
    FREQ_1M544 = 2'h1,
    FREQ_2M048 = 2'h2,
    FREQ_8M192 = 2'h3
  } dpd_freq_t;
  typedef enum logic [4:0] {
    ST_NORMAL_PRI = 5'h01,
    ST_NORMAL_SEC = 5'h02,
    ST_HOLD_PRI = 5'h04,
    ST_HOLD_SEC = 5'h08,
    ST_FREERUN = 5'h10
  } dpd_mode_t;
endpackage : dpd_pkg

// File: hw/dpd_dco_divider.sv
// Purpose: Oscillator, output divider, feedback select and Normal/Holdover/Freerun control.
// Assumes: Loop filter offset and lock flag arrive on CLK; reference pins are asynchronous.
// Notes: Clocks leave as registered levels sampled at 100 MHz, so edges carry 10 ns of jitter.
// What this block does
// - Normal mode locks to the selected reference.
// - Holdover runs at the stored Normal frequency.
// - Freerun runs at the centre frequency less the 0.03 ppm offset.
// - Derive the 65.536 MHz internal working clock.
// - Make bit, E1, T1 clocks and frame pulse.
// - Bit, E1 and T1 clocks have 50% duty.
// - Frame low marks the bit clock boundary edge.
// - 8 kHz reference aligns the output frame.
// - Line-rate references leave frame position free.
// - Backplane reference resyncs frame to input frame.
// - Feedback mux picks the matching divider output.
// - Primary or secondary state follows preferred reference.
// - Holdover reset bit in Holdover forces Freerun.
// - Accept 8k, 1.544, 2.048, 8.192 MHz references.
// - Phase lock expected within 50 seconds.
// - Mode 01 with both loss pins gives Holdover.
// - Mode 00 with loss status 11 gives Holdover.
// - Store frequency every 32 ms, alternating slots.
// - Holdover uses the older stored sample.
// - Freerun adds the -0.03 ppm design offset.
// - Backplane reference modes follow clock edge for edge.
// - Primary master uses the filtered loop offset.
// - Limit output phase slope to 7.6 ns/125 us.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module dpd_dco_divider #(
  parameter logic [32:0] LOCK_CYCLES = dpd_pkg::LOCK_CYCLES_DEF,
  parameter logic [21:0] STORE_CYCLES = dpd_pkg::STORE_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic PRIMARY_REFERENCE,
  input wire logic SECONDARY_REFERENCE,
  input wire logic BIT_CLOCK_GROUP_A,
  input wire logic BIT_CLOCK_GROUP_B,
  input wire logic BACKPLANE_FRAME_A_N,
  input wire logic BACKPLANE_FRAME_B_N,
  input wire logic PRIMARY_LOSS_INPUT,
  input wire logic SECONDARY_LOSS_INPUT,
  input wire logic PRIMARY_LOSS_STATUS,
  input wire logic SECONDARY_LOSS_STATUS,
  input wire logic signed [31:0] LOOP_FREQ_OFFSET,
  input wire logic LOOP_LOCKED,
  output logic INTERNAL_FAST_CLOCK,
  output logic BACKPLANE_BIT_CLOCK_OUT,
  output logic E1_RATE_CLOCK,
  output logic T1_RATE_CLOCK_OUT,
  output logic BACKPLANE_FRAME_PULSE_OUT_N,
  output logic PHASE_FEEDBACK,
  output logic MTIE_FEEDBACK,
  output dpd_pkg::dpd_mode_t LOOP_MODE
);
  import dpd_pkg::*;

  // Two-stage synchronisers for every pin that is not on CLK.
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  assign pins = {SECONDARY_LOSS_INPUT, PRIMARY_LOSS_INPUT, BACKPLANE_FRAME_B_N, BACKPLANE_FRAME_A_N,
                 BIT_CLOCK_GROUP_B, BIT_CLOCK_GROUP_A, SECONDARY_REFERENCE, PRIMARY_REFERENCE};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  // Control register fields and loss status.
  logic [1:0] fdm_r;
  logic hold_rst_r;
  logic pref_sec_r;
  dpd_freq_t freq_r;
  logic pri_master_r;
  logic pri_status_r;
  logic sec_status_r;
  logic wr_mode;
  assign wr_mode = WR && (ADDR == ADDR_MODE);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      fdm_r <= MODE_RESET[MODE_FDM_LSB +: 2];
      hold_rst_r <= MODE_RESET[MODE_HOLD_RST];
      pref_sec_r <= MODE_RESET[MODE_PREF_SEC];
      freq_r <= dpd_freq_t'(MODE_RESET[MODE_FREQ_LSB +: 2]);
      pri_master_r <= MODE_RESET[MODE_PRI_MASTER];
    end else if (wr_mode) begin
      fdm_r <= WDATA[MODE_FDM_LSB +: 2];
      hold_rst_r <= WDATA[MODE_HOLD_RST];
      pref_sec_r <= WDATA[MODE_PREF_SEC];
      freq_r <= dpd_freq_t'(WDATA[MODE_FREQ_LSB +: 2]);
      pri_master_r <= WDATA[MODE_PRI_MASTER];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pri_status_r <= 1'b0;
      sec_status_r <= 1'b0;
    end else begin
      pri_status_r <= PRIMARY_LOSS_STATUS;
      sec_status_r <= SECONDARY_LOSS_STATUS;
    end
  end

  // Mode state machine.
  dpd_mode_t state_r;
  dpd_mode_t state_nxt;
  dpd_mode_t norm_pick;
  dpd_mode_t hold_pick;
  logic hold_cond;
  logic is_normal;
  logic is_hold;
  logic enter_hold;
  assign hold_cond = ((fdm_r == FDM_PINS) && sync2_r[S_LOS_PRI] && sync2_r[S_LOS_SEC]) ||
                     ((fdm_r == FDM_STATUS) && pri_status_r && sec_status_r);
  assign norm_pick = pref_sec_r ? ST_NORMAL_SEC : ST_NORMAL_PRI;
  assign hold_pick = pref_sec_r ? ST_HOLD_SEC : ST_HOLD_PRI;
  assign is_normal = (state_r == ST_NORMAL_PRI) || (state_r == ST_NORMAL_SEC);
  assign is_hold = (state_r == ST_HOLD_PRI) || (state_r == ST_HOLD_SEC);
  assign enter_hold = is_normal && hold_cond;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL_PRI, ST_NORMAL_SEC: begin
        state_nxt = hold_cond ? hold_pick : norm_pick;
      end
      ST_HOLD_PRI, ST_HOLD_SEC: begin
        if (hold_rst_r) begin
          state_nxt = ST_FREERUN;
        end else if (!hold_cond) begin
          state_nxt = norm_pick;
        end else begin
          state_nxt = hold_pick;
        end
      end
      ST_FREERUN: begin
        // A held reset bit keeps the loop free running until software drops it.
        if (!hold_cond && !hold_rst_r) begin
          state_nxt = norm_pick;
        end
      end
      default: begin
        state_nxt = ST_FREERUN;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_r <= ST_FREERUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Holdover storage: two slots written alternately while locked.
  logic [21:0] store_cnt_r;
  logic store_wr_sel_r;
  logic [31:0] slot_r [2];
  logic [31:0] hold_word_r;
  logic store_pulse;
  logic store_run;
  assign store_run = is_normal && LOOP_LOCKED;
  assign store_pulse = store_run && (store_cnt_r == STORE_CYCLES - 22'h000001);

  always_ff @(posedge CLK) begin
    if (!RESETN || !store_run) begin
      store_cnt_r <= 22'h000000;
    end else if (store_pulse) begin
      store_cnt_r <= 22'h000000;
    end else begin
      store_cnt_r <= store_cnt_r + 22'h000001;
    end
  end

  logic [31:0] dco_word_r;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      store_wr_sel_r <= 1'b0;
      slot_r[0] <= FCW_NOM;
      slot_r[1] <= FCW_NOM;
    end else if (store_pulse) begin
      slot_r[store_wr_sel_r] <= dco_word_r;
      store_wr_sel_r <= ~store_wr_sel_r;
    end
  end

  // The slot due for the next write holds the sample that is 32 to 64 ms old.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      hold_word_r <= FCW_NOM;
    end else if (enter_hold) begin
      hold_word_r <= slot_r[store_wr_sel_r];
    end
  end

  // Oscillator frequency word.
  logic signed [31:0] ofs_clamped;
  logic [31:0] dco_word_nxt;
  assign ofs_clamped = (LOOP_FREQ_OFFSET > SLOPE_LIM) ? SLOPE_LIM :
                       (LOOP_FREQ_OFFSET < -SLOPE_LIM) ? -SLOPE_LIM : LOOP_FREQ_OFFSET;
  // Both Normal states take the filtered offset whatever the primary master bit; the filter itself sits upstream.
  assign dco_word_nxt = is_normal ? FCW_NOM + $unsigned(ofs_clamped) :
                        is_hold ? hold_word_r :
                        FCW_NOM - FCW_FREE_OFS;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dco_word_r <= FCW_NOM - FCW_FREE_OFS;
    end else begin
      dco_word_r <= dco_word_nxt;
    end
  end

  // Phase accumulator; its carry is one tick of the 65.536 MHz working clock.
  logic [31:0] acc_r;
  logic [32:0] acc_sum;
  logic fast_tick;
  assign acc_sum = {1'b0, acc_r} + {1'b0, dco_word_r};
  assign fast_tick = acc_sum[32];

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      acc_r <= 32'h00000000;
    end else begin
      acc_r <= acc_sum[31:0];
    end
  end

  // Frame divider and reference alignment.
  logic [12:0] cnt_r;
  logic [15:0] t1_acc_r;
  logic ref_sel_s;
  logic ref_rise;
  logic grp_sel_s;
  logic frm_fall;
  logic resync;
  logic follow;
  assign ref_sel_s = pref_sec_r ? sync2_r[S_SECONDARY_REFERENCE] : sync2_r[S_PRIMARY_REFERENCE];
  assign ref_rise = ref_sel_s && !(pref_sec_r ? sync3_r[S_SECONDARY_REFERENCE] : sync3_r[S_PRIMARY_REFERENCE]);
  assign grp_sel_s = pref_sec_r ? sync2_r[S_GRP_B] : sync2_r[S_GRP_A];
  assign frm_fall = (pref_sec_r ? sync3_r[S_FRM_B] : sync3_r[S_FRM_A]) &&
                    !(pref_sec_r ? sync2_r[S_FRM_B] : sync2_r[S_FRM_A]);
  assign follow = is_normal && (freq_r == FREQ_8M192);
  // Line-rate references never resync, so the frame lands wherever the divider stands.
  assign resync = is_normal && (((freq_r == FREQ_8K) && ref_rise) ||
                                (follow && frm_fall));

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cnt_r <= 13'h0000;
    end else if (resync) begin
      cnt_r <= 13'h0000;
    end else if (fast_tick) begin
      cnt_r <= (cnt_r == FRAME_LAST) ? 13'h0000 : cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      t1_acc_r <= 16'h0000;
    end else if (fast_tick) begin
      t1_acc_r <= t1_acc_r + T1_INC;
    end
  end

  // Output clocks; bit clock rises as the count wraps, inside the low frame window.
  logic bitclk_nxt;
  logic frame_n_nxt;
  logic fb_nxt;
  assign bitclk_nxt = follow ? grp_sel_s : !cnt_r[BITCLK_BIT];
  assign frame_n_nxt = !((cnt_r >= FRAME_LAST - FRAME_HALF + 13'h0001) || (cnt_r < FRAME_HALF));

  always_comb begin
    case (freq_r)
      FREQ_8K: fb_nxt = BACKPLANE_FRAME_PULSE_OUT_N;
      FREQ_1M544: fb_nxt = T1_RATE_CLOCK_OUT;
      FREQ_2M048: fb_nxt = E1_RATE_CLOCK;
      FREQ_8M192: fb_nxt = BACKPLANE_BIT_CLOCK_OUT;
      default: fb_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      INTERNAL_FAST_CLOCK <= 1'b0;
      BACKPLANE_BIT_CLOCK_OUT <= 1'b0;
      E1_RATE_CLOCK <= 1'b0;
      T1_RATE_CLOCK_OUT <= 1'b0;
      BACKPLANE_FRAME_PULSE_OUT_N <= 1'b1;
      PHASE_FEEDBACK <= 1'b0;
      MTIE_FEEDBACK <= 1'b0;
      LOOP_MODE <= ST_FREERUN;
    end else begin
      INTERNAL_FAST_CLOCK <= acc_r[31];
      BACKPLANE_BIT_CLOCK_OUT <= bitclk_nxt;
      E1_RATE_CLOCK <= !cnt_r[E1_BIT];
      T1_RATE_CLOCK_OUT <= t1_acc_r[15];
      BACKPLANE_FRAME_PULSE_OUT_N <= frame_n_nxt;
      PHASE_FEEDBACK <= fb_nxt;
      MTIE_FEEDBACK <= fb_nxt;
      LOOP_MODE <= state_r;
    end
  end

  // Lock watchdog: flags a loop that has not locked within the allowed time.
  logic [32:0] lock_cnt_r;
  logic lock_late_r;
  logic [2:0] ref_id_r;
  logic ref_switch;
  assign ref_switch = ref_id_r != {pref_sec_r, freq_r};

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ref_id_r <= {MODE_RESET[MODE_PREF_SEC], MODE_RESET[MODE_FREQ_LSB +: 2]};
      lock_cnt_r <= 33'h000000000;
      lock_late_r <= 1'b0;
    end else begin
      ref_id_r <= {pref_sec_r, freq_r};
      if (ref_switch || LOOP_LOCKED || !is_normal) begin
        lock_cnt_r <= 33'h000000000;
        lock_late_r <= 1'b0;
      end else if (lock_cnt_r == LOCK_CYCLES - 33'h000000001) begin
        lock_late_r <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 33'h000000001;
      end
    end
  end

  // Register read port; unmapped addresses read zero.
  logic [15:0] rd_mux;
  assign rd_mux = (ADDR == ADDR_MODE) ? {9'h000, pri_master_r, freq_r, pref_sec_r, hold_rst_r, fdm_r} :
                  (ADDR == ADDR_HKEEP) ? {7'h00, state_r, lock_late_r, LOOP_LOCKED, sec_status_r, pri_status_r} :
                  (ADDR == ADDR_HOLD_LO) ? hold_word_r[15:0] :
                  (ADDR == ADDR_HOLD_HI) ? hold_word_r[31:16] : 16'h0000;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rd_mux : 16'h0000;
    end
  end

  default clocking dpd_cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_freerun_word: assert property ((state_r == ST_FREERUN) |=> (dco_word_r == FCW_NOM - FCW_FREE_OFS))
    else $error("Freerun word differs from centre minus offset.");
  a_hold_steady: assert property (is_hold ##1 is_hold |=> (dco_word_r == hold_word_r) && $stable(dco_word_r))
    else $error("Holdover word is not steady.");
  a_hold_entry: assert property ((is_normal && hold_cond) |=> is_hold)
    else $error("Loss condition did not enter holdover.");
  a_hold_reset_free: assert property ((is_hold && hold_rst_r) |=> (state_r == ST_FREERUN) ##1 (LOOP_MODE == ST_FREERUN))
    else $error("Holdover reset bit did not force freerun.");
  a_store_alt: assert property (store_pulse |=> (store_wr_sel_r != $past(store_wr_sel_r)) && !store_pulse)
    else $error("Storage slot did not alternate.");
  a_hold_older: assert property (enter_hold |=> (hold_word_r == $past(slot_r[store_wr_sel_r])))
    else $error("Holdover did not take the older sample.");
  a_slope_limit: assert property (is_normal |=> (dco_word_r - FCW_NOM <= SLOPE_LIM) ||
                                  (FCW_NOM - dco_word_r <= SLOPE_LIM))
    else $error("Frequency offset exceeds slope limit.");
  a_frame_edge: assert property ($rose(BACKPLANE_BIT_CLOCK_OUT) && !follow && !$past(follow) |->
                                 !BACKPLANE_FRAME_PULSE_OUT_N || $past(cnt_r) != 13'h0000)
    else $error("Bit clock boundary edge outside frame pulse.");
  a_ref_align: assert property ((is_normal && freq_r == FREQ_8K && ref_rise) |=> (cnt_r == 13'h0000))
    else $error("Frame count not aligned to 8 kHz reference.");
  a_fb_select: assert property ((freq_r == FREQ_2M048) ##1 (freq_r == FREQ_2M048) |->
                                (PHASE_FEEDBACK == $past(E1_RATE_CLOCK)) && (MTIE_FEEDBACK == PHASE_FEEDBACK))
    else $error("Feedback mux picked the wrong clock.");
endmodule : dpd_dco_divider

// File: tb/dpd_ref_model.sv
// Purpose: Network reference and backplane bit clock and frame source for the oscillator bench.
// Assumes: Runs in its own time base, unrelated in phase to the system clock.
// Notes: A lost reference stands low, as a dead line would, so loss is never mistaken for an edge.
`timescale 1ns/1ps
module dpd_ref_model (
  input wire logic [1:0] FREQ,
  input wire logic LOSS,
  output logic REF,
  output logic BIT_CLK,
  output logic FRAME_N
);
  logic c1544 = 1'b0;
  logic c2048 = 1'b0;
  logic [9:0] bit_cnt = 10'h000;
  initial BIT_CLK = 1'b0;
  always #61 BIT_CLK = ~BIT_CLK;
  always #324 c1544 = ~c1544;
  always #244 c2048 = ~c2048;
  always @(posedge BIT_CLK) bit_cnt <= bit_cnt + 10'h001;
  // One bit period low in every 1024 gives the 8 kHz backplane frame.
  assign FRAME_N = (bit_cnt != 10'h000);
  // The 8 kHz reference rises at the backplane frame start, so both kinds of alignment share one epoch.
  assign REF = LOSS ? 1'b0 : (FREQ == 2'h0) ? ~bit_cnt[9] : (FREQ == 2'h1) ? c1544 :
               (FREQ == 2'h2) ? c2048 : BIT_CLK;
endmodule : dpd_ref_model

// File: tb/dpd_dco_divider_bench.sv
// Purpose: Self-checking bench for mode control, holdover storage and divider outputs.
// Assumes: Shortened store and lock counts; loop filter offset and lock flag driven by the bench.
// Notes: Clock rates are judged by edge counts over fixed windows, with tolerance for 10 ns sampling.
`timescale 1ns/1ps
module dpd_dco_divider_bench;
  import dpd_pkg::*;
  localparam int STORE_N = 50;
  localparam int LOCK_N = 200;
  localparam int FB_LO [4] = '{0, 60, 80, 325};
  localparam int FB_HI [4] = '{1, 64, 84, 331};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [1:0] ref_freq = 2'h0;
  logic ref_loss = 1'b0;
  logic ref_clk, bp_clk, bp_frame_n, fast_clk, bit_clk, e1_clk, t1_clk, frame_n, phase_fb, mtie_fb;
  logic los_pri = 1'b0, los_sec = 1'b0, sts_pri = 1'b0, sts_sec = 1'b0, locked = 1'b0, ramp = 1'b0;
  logic signed [31:0] ofs = 32'sh0;
  dpd_mode_t mode;
  logic [15:0] d, d2;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int r, h, pr, fl, fb, md, lat, oh;

  dpd_ref_model i_ref (.FREQ(ref_freq), .LOSS(ref_loss), .REF(ref_clk), .BIT_CLK(bp_clk), .FRAME_N(bp_frame_n));
  dpd_dco_divider #(.LOCK_CYCLES(33'd200), .STORE_CYCLES(22'd50)) i_dut (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PRIMARY_REFERENCE(ref_clk), .SECONDARY_REFERENCE(ref_clk), .BIT_CLOCK_GROUP_A(bp_clk),
    .BIT_CLOCK_GROUP_B(bp_clk), .BACKPLANE_FRAME_A_N(bp_frame_n), .BACKPLANE_FRAME_B_N(bp_frame_n),
    .PRIMARY_LOSS_INPUT(los_pri), .SECONDARY_LOSS_INPUT(los_sec), .PRIMARY_LOSS_STATUS(sts_pri),
    .SECONDARY_LOSS_STATUS(sts_sec), .LOOP_FREQ_OFFSET(ofs), .LOOP_LOCKED(locked),
    .INTERNAL_FAST_CLOCK(fast_clk), .BACKPLANE_BIT_CLOCK_OUT(bit_clk), .E1_RATE_CLOCK(e1_clk),
    .T1_RATE_CLOCK_OUT(t1_clk), .BACKPLANE_FRAME_PULSE_OUT_N(frame_n), .PHASE_FEEDBACK(phase_fb),
    .MTIE_FEEDBACK(mtie_fb), .LOOP_MODE(mode));

  initial begin
    forever #5 clk = ~clk;
  end
  // A ramping offset lets the stored sample reveal when it was taken.
  always @(posedge clk) if (ramp) ofs <= ofs + 32'sd1;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      failures = failures + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      failures++;
      $display("unexpected count at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic chk_mode(input dpd_mode_t exp, input int lim);
    int n;
    n = 0;
    #1;
    while (mode !== exp && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk16(16'(mode), 16'(exp));
  endtask : chk_mode

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    rd_reg(a, d);
    chk16(d, exp);
  endtask : rd_chk

  task automatic set_sts(input logic p, input logic s);
    @(posedge clk);
    sts_pri <= p;
    sts_sec <= s;
  endtask : set_sts

  task automatic set_los(input logic p, input logic s);
    @(posedge clk);
    los_pri <= p;
    los_sec <= s;
    ref_loss <= p & s;
  endtask : set_los

  task automatic measure(input int sel, input int n);
    logic s, s0, b0, p0, f0;
    {r, h, pr, fl, fb, md} = 192'h0;
    {s0, b0, p0, f0} = 4'hf;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? bit_clk : (sel == 1) ? e1_clk : (sel == 2) ? t1_clk : (sel == 3) ? phase_fb : fast_clk;
      r += int'(s & ~s0);
      h += int'(s);
      pr += int'(bp_clk & ~p0);
      fl += int'(~frame_n & f0);
      fb += int'(bit_clk & ~b0 & ~frame_n);
      md += int'(phase_fb !== mtie_fb);
      {s0, b0, p0, f0} = {s, bit_clk, bp_clk, frame_n};
    end
  endtask : measure

  // The second source edge is used, so the output has already been pulled onto the source epoch.
  task automatic latency(input logic use_ref, output int n);
    repeat (2) begin
      if (use_ref) @(posedge ref_clk);
      else @(negedge bp_frame_n);
    end
    n = 0;
    @(posedge clk);
    #1;
    while (frame_n !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : latency

  initial begin
    @(posedge clk);
    #1 chk_mode(ST_FREERUN, 0);
    chk16({15'h0, frame_n}, 16'h0001);
    @(posedge clk);
    resetn <= 1'b1;
    rd_chk(ADDR_MODE, 16'h0040);
    chk_mode(ST_NORMAL_PRI, 10);
    rd_chk(ADDR_HKEEP, 16'h0010);
    @(posedge clk);
    #1 chk16(rdata, 16'h0000);
    wr_reg(4'h7, 16'hffff);
    rd_chk(4'h7, 16'h0000);
    wr_reg(ADDR_HKEEP, 16'hffff);
    rd_chk(ADDR_HKEEP, 16'h0010);
    repeat (LOCK_N) @(posedge clk);
    rd_chk(ADDR_HKEEP, 16'h0018);
    @(posedge clk);
    locked <= 1'b1;
    ramp <= 1'b1;
    rd_chk(ADDR_HKEEP, 16'h0014);
    $display("register and lock test done");
    repeat (4 * STORE_N) @(posedge clk);
    oh = int'(ofs);
    sts_pri <= 1'b1;
    sts_sec <= 1'b1;
    chk_mode(ST_HOLD_PRI, 6);
    rd_reg(ADDR_HOLD_LO, d2);
    rd_reg(ADDR_HOLD_HI, d);
    chk_rng(int'({d, d2} - FCW_NOM), oh - 101, oh - 47);
    repeat (20) @(posedge clk);
    rd_chk(ADDR_HOLD_LO, d2);
    rd_chk(ADDR_HKEEP, 16'h0047);
    wr_reg(ADDR_MODE, 16'h0044);
    wr_reg(ADDR_MODE, 16'h0048);
    chk_mode(ST_FREERUN, 6);
    repeat (10) @(posedge clk);
    chk_mode(ST_FREERUN, 0);
    set_sts(1'b0, 1'b0);
    chk_mode(ST_NORMAL_SEC, 6);
    set_sts(1'b1, 1'b1);
    chk_mode(ST_HOLD_SEC, 6);
    wr_reg(ADDR_MODE, 16'h0041);
    chk_mode(ST_NORMAL_PRI, 6);
    repeat (10) @(posedge clk);
    chk_mode(ST_NORMAL_PRI, 0);
    set_sts(1'b0, 1'b0);
    set_los(1'b1, 1'b1);
    chk_mode(ST_HOLD_PRI, 8);
    set_los(1'b1, 1'b0);
    chk_mode(ST_NORMAL_PRI, 8);
    set_los(1'b1, 1'b1);
    wr_reg(ADDR_MODE, 16'h0042);
    repeat (10) @(posedge clk);
    chk_mode(ST_NORMAL_PRI, 0);
    set_los(1'b0, 1'b0);
    wr_reg(ADDR_MODE, 16'h0040);
    set_sts(1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk_mode(ST_NORMAL_PRI, 0);
    set_sts(1'b0, 1'b0);
    // A far negative offset must be clamped; slowing the oscillator keeps frame alignment checks safe.
    ramp <= 1'b0;
    @(posedge clk);
    ofs <= 32'sh80010000;
    $display("mode test done");
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      ref_freq <= 2'(f);
      wr_reg(ADDR_MODE, 16'h0040 | 16'(f << 4));
      repeat (200) @(posedge clk);
      measure(3, 4000);
      chk_rng(r, FB_LO[f], FB_HI[f]);
      chk_rng(md, 0, 0);
      if (f == 3) chk_rng(r, pr - 1, pr + 1);
      if (f == 0 || f == 3) begin
        latency(f == 0, lat);
        chk_rng(lat, 3, 9);
      end
      if (f == 2) begin
        measure(0, 13000);
        chk_rng(r, 1062, 1068);
        chk_rng(h, 5850, 7150);
        chk_rng(fl, 1, 2);
        chk_rng(fb, fl, 2 * fl + 1);
        measure(1, 3000);
        chk_rng(r, 59, 64);
        chk_rng(h, 1350, 1650);
        measure(2, 3000);
        chk_rng(r, 44, 48);
        chk_rng(h, 1350, 1650);
        // Sampled at 100 MHz the 65.536 MHz clock aliases to about 34.46 rising edges per 100 cycles.
        measure(4, 1000);
        chk_rng(r, 341, 348);
        chk_rng(h, 450, 550);
      end
    end
    $display("divider test done");
    test_done();
  end
endmodule : dpd_dco_divider_bench
